// ==== verilog/uvx_pkg.sv ====
`default_nettype none
package uvx_pkg;
  localparam logic [7:0] INS_VAR_WITH_X = 8'h2b; // 43
  localparam logic [7:0] INS_X_WITH_VAR = 8'h2c; // 44
  localparam logic [7:0] STATUS_OK      = 8'h64; // 100
  localparam logic [3:0] OP_ADD  = 4'h0;
  localparam logic [3:0] OP_SUB  = 4'h1;
  localparam logic [3:0] OP_MUL  = 4'h2;
  localparam logic [3:0] OP_DIV  = 4'h3;
  localparam logic [3:0] OP_MOD  = 4'h4;
  localparam logic [3:0] OP_AND  = 4'h5;
  localparam logic [3:0] OP_OR   = 4'h6;
  localparam logic [3:0] OP_XOR  = 4'h7;
  localparam logic [3:0] OP_NOT  = 4'h8;
  localparam logic [3:0] OP_LOAD = 4'h9;
  localparam logic [3:0] OP_SWAP = 4'ha;
  localparam logic [3:0] OP_COMP = 4'hb;
  // byte positions inside a nine-byte frame
  localparam logic [3:0] POS_ADDR = 4'h0;
  localparam logic [3:0] POS_INS  = 4'h1;
  localparam logic [3:0] POS_TYPE = 4'h2;
  localparam logic [3:0] POS_BANK = 4'h3;
  localparam logic [3:0] POS_CSUM = 4'h8;
  localparam logic [3:0] POS_LAST = 4'h8;
  localparam logic [7:0] MODULE_ADDR_DEF = 8'h01;
  localparam logic [7:0] HOST_ADDR_DEF   = 8'h02;
  localparam logic [31:0] VAR_RESET = 32'h0000_0000;
  localparam logic [31:0] X_RESET   = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_RECV  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_REPLY = 3'b100
  } uvx_state_t;
endpackage : uvx_pkg
`default_nettype wire

// ==== verilog/uvx_exec.sv ====
`timescale 1ns/100ps
`default_nettype none
module uvx_exec #(
  parameter logic [7:0] MODULE_ADDR = uvx_pkg::MODULE_ADDR_DEF,
  parameter logic [7:0] HOST_ADDR   = uvx_pkg::HOST_ADDR_DEF,
  parameter int         NUM_VARS    = 256
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // command byte stream from the host
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_ready_o,
  // reply byte stream to the host
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  input  wire logic        tx_ready_i,
  // observation
  output logic [31:0]      xreg_o,
  output logic             csum_err_o
);
  import uvx_pkg::*;

  // result of one operation; dest is the operand that receives it
  // limitation: the most negative value divided by -1 wraps to itself
  function automatic logic [31:0] alu(input logic [31:0] dest,
                                      input logic [31:0] src,
                                      input logic [3:0]  op);
    logic [31:0] r;
    r = dest;
    case (op)
      OP_ADD:  r = dest + src;
      OP_SUB:  r = dest - src;
      OP_MUL:  r = dest * src;
      OP_DIV:  r = $signed(dest) / $signed(src);
      OP_MOD:  r = $signed(dest) % $signed(src);
      OP_AND:  r = dest & src;
      OP_OR:   r = dest | src;
      OP_XOR:  r = dest ^ src;
      OP_NOT:  r = ~src;
      OP_LOAD: r = src;
      OP_SWAP: r = src;
      default: r = dest;
    endcase
    return r;
  endfunction : alu

  // running modulo-256 byte sum
  function automatic logic [7:0] sum8(input logic [7:0] a,
                                      input logic [7:0] b);
    return 8'(a + b);
  endfunction : sum8

  // sequencer state, byte position and running sum
  uvx_state_t  state_reg;
  uvx_state_t  state_next;
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;
  logic [7:0]  sum_reg;
  logic [7:0]  sum_next;
  // header fields of the frame in flight, then the X register, reply byte and checksum error flag
  logic [7:0]  addr_reg;
  logic [7:0]  addr_next;
  logic [7:0]  ins_reg;
  logic [7:0]  ins_next;
  logic [3:0]  typ_reg;
  logic [3:0]  typ_next;
  logic [7:0]  idx_reg;
  logic [7:0]  idx_next;
  logic [31:0] x_reg;
  logic [31:0] x_next;
  logic [7:0]  tx_reg;
  logic [7:0]  tx_next;
  logic        err_reg;
  logic        err_next;
  // user variable bank: one write port, read by the captured index
  logic        var_we;
  logic [31:0] var_wd;
  logic [31:0] var_mem [NUM_VARS];
  logic [31:0] var_rd;
  // handshake qualifiers and execution helpers
  logic        rx_take;
  logic        tx_take;
  logic        div_zero;
  logic [7:0]  reply_sum;

  assign var_rd     = var_mem[idx_reg];
  assign rx_ready_o = (state_reg == ST_RECV);
  assign tx_valid_o = (state_reg == ST_REPLY);
  assign tx_data_o  = tx_reg;
  assign xreg_o     = x_reg;
  assign csum_err_o = err_reg;
  assign rx_take    = rx_valid_i && rx_ready_o;
  assign tx_take    = tx_valid_o && tx_ready_i;
  // reply value bytes are zero, so only four header bytes add in
  assign reply_sum  = sum8(sum8(HOST_ADDR, MODULE_ADDR),
                           sum8(STATUS_OK, ins_reg));

  // byte selection of the reply frame
  function automatic logic [7:0] reply_byte(input logic [3:0] pos,
                                            input logic [7:0] ins,
                                            input logic [7:0] csum);
    logic [7:0] b;
    b = 8'h00;
    case (pos)
      4'h0:    b = HOST_ADDR;
      4'h1:    b = MODULE_ADDR;
      4'h2:    b = STATUS_OK;
      4'h3:    b = ins;
      POS_CSUM: b = csum;
      default: b = 8'h00; // value field bytes are always zero
    endcase
    return b;
  endfunction : reply_byte

  // frame capture, execution and reply sequencing
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sum_next   = sum_reg;
    addr_next  = addr_reg;
    ins_next   = ins_reg;
    typ_next   = typ_reg;
    idx_next   = idx_reg;
    x_next     = x_reg;
    tx_next    = tx_reg;
    err_next   = err_reg;
    var_we     = 1'b0;
    var_wd     = var_rd;
    div_zero   = 1'b0;
    case (state_reg)
      ST_RECV: begin
        if (rx_take) begin
          // fields land by position in the frame
          if (cnt_reg == POS_ADDR) addr_next = rx_data_i;
          if (cnt_reg == POS_INS)  ins_next  = rx_data_i;
          if (cnt_reg == POS_TYPE) typ_next  = rx_data_i[3:0];
          if (cnt_reg == POS_BANK) idx_next  = rx_data_i;
          // value bytes four to seven only feed the sum
          sum_next = sum8(sum_reg, rx_data_i);
          cnt_next = 4'(cnt_reg + 4'h1);
          if (cnt_reg == POS_LAST) begin
            cnt_next = 4'h0;
            sum_next = 8'h00;
            err_next = (rx_data_i != sum_reg);
            // bad sum or another address: drop the frame silently
            if (rx_data_i == sum_reg && addr_reg == MODULE_ADDR &&
                (ins_reg == INS_VAR_WITH_X ||
                 ins_reg == INS_X_WITH_VAR) &&
                typ_reg <= OP_COMP) begin
              state_next = ST_EXEC;
            end
          end
        end
      end
      ST_EXEC: begin
        // divide by zero leaves both operands untouched
        div_zero = (typ_reg == OP_DIV || typ_reg == OP_MOD) &&
                   ((ins_reg == INS_VAR_WITH_X) ? (x_reg == 32'h0)
                                                : (var_rd == 32'h0));
        if (ins_reg == INS_VAR_WITH_X) begin
          // variable is destination, X is source
          var_wd = alu(var_rd, x_reg, typ_reg);
          var_we = !div_zero && typ_reg != OP_COMP;
          if (typ_reg == OP_SWAP) x_next = var_rd;
        end else begin
          // X is destination, variable is source
          if (!div_zero && typ_reg != OP_COMP) begin
            x_next = alu(x_reg, var_rd, typ_reg);
          end
          var_wd = x_reg;
          var_we = (typ_reg == OP_SWAP);
        end
        tx_next    = reply_byte(4'h0, ins_reg, reply_sum);
        state_next = ST_REPLY;
      end
      ST_REPLY: begin
        // status ok reply with the echoed instruction
        if (tx_take) begin
          cnt_next = 4'(cnt_reg + 4'h1);
          tx_next  = reply_byte(4'(cnt_reg + 4'h1), ins_reg, reply_sum);
          if (cnt_reg == POS_LAST) begin
            cnt_next   = 4'h0;
            state_next = ST_RECV;
          end
        end
      end
      default: state_next = ST_RECV;
    endcase
  end

  // state registers; the whole variable bank clears on reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_RECV;
      cnt_reg   <= 4'h0;
      sum_reg   <= 8'h00;
      addr_reg  <= 8'h00;
      ins_reg   <= 8'h00;
      typ_reg   <= 4'h0;
      idx_reg   <= 8'h00;
      x_reg     <= X_RESET;
      tx_reg    <= 8'h00;
      err_reg   <= 1'b0;
      for (int i = 0; i < NUM_VARS; i++) var_mem[i] <= VAR_RESET;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sum_reg   <= sum_next;
      addr_reg  <= addr_next;
      ins_reg   <= ins_next;
      typ_reg   <= typ_next;
      idx_reg   <= idx_next;
      x_reg     <= x_next;
      tx_reg    <= tx_next;
      err_reg   <= err_next;
      if (var_we) var_mem[idx_reg] <= var_wd;
    end
  end
endmodule : uvx_exec
`default_nettype wire

// ==== bench/uvx_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module uvx_asserts
  import uvx_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  // command and reply streams
  input wire logic       rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic       rx_ready_o,
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_ready_i,
  // observation
  input wire logic [31:0] xreg_o,
  input wire logic       csum_err_o
);
  logic [3:0] n, t;
  logic [7:0] s, b[4];
  wire tk = rx_valid_i && rx_ready_o;
  wire last = tk && n == 4'h8;
  wire sum_ok = rx_data_i == s;
  wire good = last && sum_ok && b[0] == MODULE_ADDR_DEF && b[2][3:0] < 4'hc
    && b[1] inside {INS_VAR_WITH_X, INS_X_WITH_VAR};
  // expected reply byte; value field is always zero
  localparam logic [7:0] HEAD_SUM =
    8'(HOST_ADDR_DEF + MODULE_ADDR_DEF + STATUS_OK);
  wire [7:0] eb = t == 4'h0 ? HOST_ADDR_DEF : t == 4'h1 ? MODULE_ADDR_DEF :
    t == 4'h2 ? STATUS_OK : t == 4'h3 ? b[1] :
    t == 4'h8 ? 8'(HEAD_SUM + b[1]) : 8'h00;
  // frame position, running sum and header bytes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      n <= 4'h0;
      t <= 4'h0;
      s <= 8'h00;
      b <= '{default: 8'h00};
    end else begin
      if (tk) n <= last ? 4'h0 : n + 4'h1;
      if (tk) s <= last ? 8'h00 : s + rx_data_i;
      if (tk && n < 4'h4) b[n[1:0]] <= rx_data_i;
      if (tx_valid_o && tx_ready_i) t <= t == 4'h8 ? 4'h0 : t + 4'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence frame_good; good; endsequence
  sequence reply_start;
    !rx_ready_o ##1 tx_valid_o && tx_data_o == HOST_ADDR_DEF;
  endsequence
  reply_first_a: assert property (frame_good |=> reply_start)
    else $error("no reply after a good frame");
  drop_frame_a: assert property (
    last && !good |-> ##2 !tx_valid_o)
    else $error("reply to a dropped frame");
  csum_flag_a: assert property (
    last |=> csum_err_o != $past(sum_ok))
    else $error("checksum flag wrong");
  one_way_a: assert property (!(rx_ready_o && tx_valid_o))
    else $error("receive and reply at once");
  byte_stands_a: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte moved before taken");
  reply_byte_a: assert property (
    tx_valid_o |-> tx_data_o == eb)
    else $error("reply byte wrong");
  reply_end_a: assert property (
    tx_valid_o && tx_ready_i && t == 4'h8 |=> rx_ready_o && !tx_valid_o)
    else $error("reply did not end after nine bytes");
  x_kept_a: assert property (
    good && b[1] == INS_VAR_WITH_X && b[2][3:0] != OP_SWAP
    |=> $stable(xreg_o) [*3])
    else $error("x register changed by variable update");
  x_comp_a: assert property (
    good && b[1] == INS_X_WITH_VAR && b[2][3:0] == OP_COMP
    |=> $stable(xreg_o) [*3])
    else $error("x register changed by compare");
endmodule : uvx_asserts
bind uvx_exec uvx_asserts chk (.clk_i, .rst_n_i, .rx_valid_i, .rx_data_i,
  .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .xreg_o, .csum_err_o);
`default_nettype wire

// ==== bench/uvx_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module uvx_host (
  // clock
  input wire logic       clk_i,
  // command stream
  output logic           rx_valid_o,
  output logic [7:0]     rx_data_o,
  input wire logic       rx_ready_i,
  // reply stream
  input wire logic       tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic           tx_ready_o
);
  logic [7:0] q[$];
  // idle lines at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b0;
  end
  // one frame, each byte held until taken
  task send(input logic [7:0] a, ins, ty, bk, input logic bad);
    logic [7:0] f[9];
    logic ok;
    f = '{a, ins, ty, bk, 0, 0, 0, 0, 0};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    f[8] += {7'h0, bad};
    foreach (f[i]) begin
      @(negedge clk_i);
      rx_valid_o = 1'b1;
      rx_data_o = f[i];
      do begin
        ok = rx_ready_i;
        @(posedge clk_i);
        if (!ok) @(negedge clk_i);
      end while (!ok);
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o; // released line must not keep the last byte
  endtask : send
  // collect nine reply bytes, stalling every other cycle when slow
  task recv(input logic slow);
    int c;
    q.delete();
    c = 0;
    while (q.size() < 9) begin
      @(negedge clk_i);
      c++;
      tx_ready_o = !slow || c[0];
      if (tx_ready_o && tx_valid_i) q.push_back(tx_data_i);
      @(posedge clk_i);
    end
  endtask : recv
endmodule : uvx_host
`default_nettype wire

// ==== bench/user_var_x_reg_arith_exec_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module user_var_x_reg_arith_exec_bench;
  import uvx_pkg::*;
  logic clk_i = 0, rst_n_i = 0, rx_valid, tx_ready, rx_ready_o, tx_valid_o;
  logic csum_err_o;
  logic [7:0] rx_data, tx_data_o;
  logic [31:0] xreg_o, seed = 51, x = 0, r, vars[256];
  int errors = 0, checks = 0;
  uvx_exec uut (.clk_i, .rst_n_i, .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i(tx_ready), .xreg_o,
    .csum_err_o);
  uvx_host host (.clk_i, .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_ready_o(tx_ready));
  initial forever #20 clk_i = ~clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // model result with write flag on top; divide by zero writes nothing
  function automatic logic [32:0] f(int a, b, logic [3:0] op);
    int q;
    case (op)
      0: q = a + b;
      1: q = a - b;
      2: q = a * b;
      3: q = b == -1 ? -a : a / (b ? b : 1);
      4: q = b == -1 ? 0 : a % (b ? b : 1);
      5: q = a & b;
      6: q = a | b;
      7: q = a ^ b;
      8: q = ~b;
      default: q = b;
    endcase
    return {!(op == OP_COMP || op inside {OP_DIV, OP_MOD} && b == 0), q};
  endfunction : f
  task chk(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask : chk
  task finish_test();
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // send a frame, update the model, compare reply and x register
  task frame(input logic [7:0] a, ins, ty, bk, input logic bad, slow);
    logic [32:0] w;
    logic [7:0] e[9];
    logic ok;
    ok = a == MODULE_ADDR_DEF && ty[3:0] < 4'hc && !bad
      && ins inside {INS_VAR_WITH_X, INS_X_WITH_VAR};
    host.send(a, ins, ty, bk, bad);
    if (!ok) begin
      repeat (4) @(negedge clk_i);
      chk(tx_valid_o, 0);
      chk(csum_err_o, bad);
      return;
    end
    if (ins == INS_VAR_WITH_X) w = f(vars[bk], x, ty[3:0]);
    else w = f(x, vars[bk], ty[3:0]);
    if (ty[3:0] == OP_SWAP) {vars[bk], x} = {x, vars[bk]};
    else if (w[32] && ins == INS_VAR_WITH_X) vars[bk] = w[31:0];
    else if (w[32]) x = w[31:0];
    e = '{HOST_ADDR_DEF, MODULE_ADDR_DEF, STATUS_OK, ins, 0, 0, 0, 0, 0};
    for (int i = 0; i < 8; i++) e[8] += e[i];
    host.recv(slow);
    foreach (e[i]) chk(host.q[i], e[i]);
    @(negedge clk_i);
    chk(xreg_o, x);
  endtask : frame
  // main sequence: sweep all types, refused frames, then random traffic
  initial begin
    foreach (vars[i]) vars[i] = 0;
    repeat (12) @(negedge clk_i);
    rst_n_i = 1;
    frame(8'h01, 8'h2b, 8'h08, 8'h1b, 0, 0);
    for (int i = 0; i < 24; i++)
      frame(8'h01, i < 12 ? 8'h2b : 8'h2c, 8'(i % 12), 8'h1b, 0,
        i[0]);
    frame(8'h01, 8'h2b, 8'h00, 8'h00, 1, 0);
    frame(8'h05, 8'h2b, 8'h00, 8'h00, 0, 0);
    frame(8'h01, 8'h2d, 8'h00, 8'h00, 0, 0);
    frame(8'h01, 8'h2c, 8'h0c, 8'h00, 0, 0);
    // random types carry a random upper nibble, which must be ignored
    repeat (80) begin
      r = rnd();
      frame(8'h01, r[3] ? 8'h2c : 8'h2b, {r[11:8], 4'(r[7:4] % 4'hc)},
        {8{r[0]}} ^ {7'h0, r[1]}, 0, r[2]);
    end
    // mid-run reset clears x and the bank; then load a variable into x
    rst_n_i = 0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1;
    x = 0;
    foreach (vars[i]) vars[i] = 0;
    chk(xreg_o, x);
    frame(8'h01, 8'h2c, 8'h09, 8'h01, 0, 0);
    finish_test();
  end
  // watchdog against a hung handshake
  initial begin
    #1000000;
    errors++;
    finish_test();
  end
endmodule : user_var_x_reg_arith_exec_bench
`default_nettype wire
